// ==== verilog/rs_seq_pkg.sv ====
/*
  Constants shared by the rolling-shutter exposure sequencer: register map, field
  positions, reset values and row timing. Assumes a 32-bit APB register bus.
*/
package rs_seq_pkg;

  // ----------------------------------------------------------------------
  // Row timing
  // ----------------------------------------------------------------------
  localparam int unsigned ROW_CLKS_LARGE = 2624;
  localparam int unsigned ROW_CLKS_SMALL = 2592;
  localparam int unsigned ROWS_LARGE = 2160;
  localparam int unsigned ROWS_SMALL = 2048;
  localparam int unsigned HALVES = 2;
  localparam int unsigned TRIG_MIN_CLKS = 2;
  localparam int unsigned EXT_MIN_EXPO_ROWS = 3;
  localparam int unsigned MIN_EXPO_ROWS = 1;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] EXPO_ADDR = 12'h004;
  localparam logic [11:0] CYCLE_ADDR = 12'h008;
  localparam logic [11:0] ROWS_ADDR = 12'h00c;
  localparam logic [11:0] SWTRIG_ADDR = 12'h010;
  localparam logic [11:0] STATUS_ADDR = 12'h014;
  localparam logic [11:0] ROWCNT_ADDR = 12'h018;

  // Control fields.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam int unsigned CTRL_OVL_BIT = 2;
  localparam int unsigned CTRL_SMALL_BIT = 3;
  localparam int unsigned CTRL_W = 4;

  // Reset values.
  localparam logic [31:0] EXPO_RST = 32'h0000_0010;
  localparam logic [31:0] CYCLE_RST = 32'h0000_1000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FLUSH,
    ST_DISCARD,
    ST_EXPOSE,
    ST_SIGNAL,
    ST_HOLD
  } seq_state_t;

endpackage

// ==== verilog/rs_exposure_sequencer.sv ====
/*
  Rolling-shutter exposure sequencer: times flush, discard and signal readouts in
  row periods, drives the ready and exposure indicators. Assumes one clock, an APB
  master, and an external trigger synchronous to pclk.
*/
// The placing of the registers and the APB register port are this design's own decisions.
// Function
// - Large variant: one row period equals 2624 clocks; all row timing counts that.
// - Small variant: one row period equals 2592 clocks instead.
// - Large variant: 2160-row frame read in two halves takes 1080 rows.
// - Small variant: 2048-row frame read in two halves takes 1024 rows.
// - Sub-image readout length scales with the selected row count.
// - Trigger pulses of at least 2 clocks are detected; source holds them so long.
// - Internal non-overlap: flush, release, discard readout begins exposure.
// - Internal non-overlap: signal readout after exposure, then flush until cycle ends.
// - Internal non-overlap: exposure 1 row up, cycle at least expo+frame+row.
// - All-rows indicator high only while every row exposes together.
// - Any-row indicator high while at least one row exposes.
// - Overlap: next exposure starts during readout, cycle equals exposure; the code makes the cycle exposure plus one row.
// - Overlap short exposure: frame readout sets the cycle.
// - Overlap long exposure: exposure sets the cycle.
// - Long overlap: each row re-exposes as soon as it is read.
// - External non-overlap: pin or software trigger, same sequence.
// - Awaiting trigger: flush held, dummy-row scan, ready output high.
// - On trigger: release flush, discard, expose, signal readout, flush again.
// - External: exposure at least 3 rows, cycle expo+frame+row, pulse 2 clocks.
// - Triggers arriving while ready is low are ignored.
// - Idle scan repeatedly reads a virtual row until a trigger.
// - Rows offset by one row; first- and last-row indicators mark them.
`timescale 1ns/1ns

module rs_exposure_sequencer #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger,
  output logic array_flush,
  output logic readout_active,
  output logic readout_discard,
  output logic row_strobe,
  output logic dummy_row_read,
  output logic trigger_ready,
  output logic expose_first,
  output logic expose_last,
  output logic expose_all,
  output logic expose_any
);
  import rs_seq_pkg::*;

  // Narrower counters cannot hold a long exposure in rows; wider ones exceed the bus word.
  if (CNT_W < 16 || CNT_W > 32) begin : cnt_w_check
    $error("CNT_W must lie between 16 and 32.");
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] expo_q;
  logic [31:0] cycle_q;
  logic [31:0] rows_q;
  logic sw_trig_q;
  logic [CNT_W-1:0] row_cnt_q;
  seq_state_t state_q;
  logic wr_en;
  logic addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == CTRL_ADDR) || (paddr == EXPO_ADDR) || (paddr == CYCLE_ADDR)
    || (paddr == ROWS_ADDR) || (paddr == SWTRIG_ADDR) || (paddr == STATUS_ADDR)
    || (paddr == ROWCNT_ADDR);
  // Unmapped offsets are refused with an error and read back as zero.
  assign pslverr = psel && penable && !addr_ok;

  // Configuration registers; a zero row count selects the full array height.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      expo_q <= EXPO_RST;
      cycle_q <= CYCLE_RST;
      rows_q <= ZERO32;
    end else if (wr_en) begin
      if (paddr == CTRL_ADDR) ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == EXPO_ADDR) expo_q <= pwdata;
      if (paddr == CYCLE_ADDR) cycle_q <= pwdata;
      if (paddr == ROWS_ADDR) rows_q <= pwdata;
    end
  end

  // Software trigger is a one-cycle pulse from a write of bit 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_trig_q <= 1'b0;
    end else begin
      sw_trig_q <= wr_en && (paddr == SWTRIG_ADDR) && pwdata[0];
    end
  end

  // Read data comes from a flop, registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO32;
    end else if (psel && !penable) begin
      unique case (paddr)
        CTRL_ADDR: prdata <= 32'(ctrl_q);
        EXPO_ADDR: prdata <= expo_q;
        CYCLE_ADDR: prdata <= cycle_q;
        ROWS_ADDR: prdata <= rows_q;
        STATUS_ADDR: prdata <= {24'h00_0000, expose_all, expose_any, trigger_ready,
          array_flush, 1'b0, state_q};
        ROWCNT_ADDR: prdata <= 32'(row_cnt_q);
        default: prdata <= ZERO32;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Row timing
  // ----------------------------------------------------------------------
  logic run;
  logic ext_mode;
  logic ovl_mode;
  logic [11:0] row_len;
  logic [11:0] clk_cnt_q;
  logic row_tick;
  logic [CNT_W-1:0] frame_rows;
  logic [CNT_W-1:0] expo_rows;
  logic [CNT_W-1:0] cycle_rows;
  logic trig_evt;

  assign run = ctrl_q[CTRL_RUN_BIT];
  assign ext_mode = ctrl_q[CTRL_EXT_BIT];
  assign ovl_mode = ctrl_q[CTRL_OVL_BIT] && !ext_mode;
  assign row_len = ctrl_q[CTRL_SMALL_BIT] ? 12'(ROW_CLKS_SMALL) : 12'(ROW_CLKS_LARGE);
  assign row_tick = (clk_cnt_q == row_len - 12'h001);

  // Two halves read in parallel, so a frame costs half its row count.
  always_comb begin
    if (rows_q == ZERO32) begin
      frame_rows = ctrl_q[CTRL_SMALL_BIT] ? CNT_W'(ROWS_SMALL / HALVES)
        : CNT_W'(ROWS_LARGE / HALVES);
    end else begin
      frame_rows = CNT_W'((rows_q + 32'h0000_0001) >> 1);
    end
  end

  // Exposure is clamped to its least legal value for the selected mode.
  // A zero setting would otherwise never expire and stall the sequence.
  always_comb begin
    expo_rows = expo_q[CNT_W-1:0];
    if (ext_mode && expo_rows < CNT_W'(EXT_MIN_EXPO_ROWS)) begin
      expo_rows = CNT_W'(EXT_MIN_EXPO_ROWS);
    end else if (expo_rows < CNT_W'(MIN_EXPO_ROWS)) begin
      expo_rows = CNT_W'(MIN_EXPO_ROWS);
    end
    cycle_rows = cycle_q[CNT_W-1:0];
  end

  // Clock counter marks row boundaries. A taken trigger restarts it, so that the
  // readout it starts spans whole rows and the start delay stays within one row.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt_q <= 12'h000;
    end else if (!run || row_tick || trig_evt) begin
      clk_cnt_q <= 12'h000;
    end else begin
      clk_cnt_q <= clk_cnt_q + 12'h001;
    end
  end

  // Free-running row count, readable so that software can pace itself by rows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_cnt_q <= '0;
    end else if (!run) begin
      row_cnt_q <= '0;
    end else if (row_tick) begin
      row_cnt_q <= row_cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------------
  logic trig_d1_q;
  logic trig_seen_q;
  logic trig_pulse;

  // A pulse is taken after two high samples, so two clocks always suffice.
  // Holding the input longer does not fire again: a new pulse needs a low sample first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d1_q <= 1'b0;
      trig_seen_q <= 1'b0;
    end else begin
      trig_d1_q <= ext_trigger;
      trig_seen_q <= ext_trigger && trig_d1_q;
    end
  end
  assign trig_pulse = ext_trigger && trig_d1_q && !trig_seen_q;
  assign trig_evt = trigger_ready && (trig_pulse || sw_trig_q);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] phase_cnt_q;
  logic [CNT_W-1:0] cycle_cnt_q;
  logic [CNT_W-1:0] expo_cnt_q;
  logic expo_run_q;
  logic phase_end;
  logic expo_done;
  logic cycle_done;

  assign phase_end = row_tick && (phase_cnt_q == frame_rows - CNT_W'(1));
  assign expo_done = row_tick && expo_run_q && (expo_cnt_q >= expo_rows - CNT_W'(1));
  // The flush state waits for one more row boundary, so the hold ends a row early.
  assign cycle_done = (cycle_cnt_q + CNT_W'(1) >= cycle_rows);

  // Frame rows within a readout; reset at each readout start.
  // Readouts always begin on a row boundary, so the count covers whole rows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_q <= '0;
    end else if (state_q != ST_DISCARD && state_q != ST_SIGNAL) begin
      phase_cnt_q <= '0;
    end else if (phase_end) begin
      phase_cnt_q <= '0;
    end else if (row_tick) begin
      phase_cnt_q <= phase_cnt_q + CNT_W'(1);
    end
  end

  // Row-1 exposure runs from the discard pass of row 1, and in overlap also from its signal pass, until its expiry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expo_run_q <= 1'b0;
      expo_cnt_q <= '0;
    end else if (!run || state_q == ST_IDLE || state_q == ST_FLUSH || state_q == ST_HOLD) begin
      expo_run_q <= 1'b0;
      expo_cnt_q <= '0;
    end else if (row_tick && phase_cnt_q == '0
                 && (state_q == ST_DISCARD || (state_q == ST_SIGNAL && ovl_mode))) begin
      expo_run_q <= 1'b1;
      expo_cnt_q <= '0;
    end else if (expo_done) begin
      expo_run_q <= 1'b0;
    end else if (row_tick && expo_run_q) begin
      expo_cnt_q <= expo_cnt_q + CNT_W'(1);
    end
  end

  // Cycle counter in rows, restarted when each discard readout begins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_cnt_q <= '0;
    end else if (state_q == ST_FLUSH || state_q == ST_IDLE) begin
      cycle_cnt_q <= '0;
    end else if (row_tick) begin
      cycle_cnt_q <= cycle_cnt_q + CNT_W'(1);
    end
  end

  // Phase machine. Overlap keeps cycling readouts, with at least one row of exposure state between them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else if (!run) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_FLUSH;
        end
        ST_FLUSH: begin
          // External readout starts on the trigger itself, without waiting for a row boundary.
          if (ext_mode ? trig_evt : row_tick) begin
            state_q <= ST_DISCARD;
          end
        end
        ST_DISCARD: begin
          if (phase_end) begin
            state_q <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          // Short overlap exposure may end during readout; start signal then.
          if (expo_done || (!expo_run_q && row_tick)) begin
            state_q <= ST_SIGNAL;
          end
        end
        ST_SIGNAL: begin
          if (phase_end) begin
            if (ovl_mode) begin
              state_q <= ST_EXPOSE;
            end else begin
              state_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // External mode returns to flush at once and waits there for a trigger.
          // Internal mode holds the flush until the programmed cycle has run out.
          if (ext_mode) begin
            state_q <= ST_FLUSH;
          end else if (cycle_done) begin
            state_q <= ST_FLUSH;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] last_cnt_q;
  logic last_run_q;

  // Last row starts one row after row 1 and ends one frame after row 1 ends.
  // Its window is tracked in rows only; it does not follow row 1 clock by clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cnt_q <= '0;
      last_run_q <= 1'b0;
    end else if (!run) begin
      last_cnt_q <= '0;
      last_run_q <= 1'b0;
    end else if (row_tick) begin
      last_cnt_q <= expo_run_q ? '0 : last_cnt_q + CNT_W'(1);
      last_run_q <= expo_run_q
        ? (last_cnt_q >= frame_rows - CNT_W'(2)) || last_run_q
        : last_run_q && (last_cnt_q < frame_rows - CNT_W'(1));
    end
  end

  // Indicator and control flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_flush <= 1'b1;
      readout_active <= 1'b0;
      readout_discard <= 1'b0;
      row_strobe <= 1'b0;
      dummy_row_read <= 1'b0;
      trigger_ready <= 1'b0;
      expose_first <= 1'b0;
      expose_last <= 1'b0;
      expose_all <= 1'b0;
      expose_any <= 1'b0;
    end else begin
      array_flush <= (state_q == ST_IDLE) || (state_q == ST_FLUSH) || (state_q == ST_HOLD);
      readout_active <= (state_q == ST_DISCARD) || (state_q == ST_SIGNAL);
      readout_discard <= (state_q == ST_DISCARD);
      row_strobe <= row_tick && ((state_q == ST_DISCARD) || (state_q == ST_SIGNAL));
      dummy_row_read <= row_tick && (state_q == ST_FLUSH) && ext_mode
        && !trig_evt;
      trigger_ready <= ext_mode && (state_q == ST_FLUSH) && !trig_evt;
      expose_first <= expo_run_q;
      expose_last <= last_run_q;
      expose_all <= expo_run_q && last_run_q;
      expose_any <= expo_run_q || last_run_q;
    end
  end

endmodule

// ==== testbench/rs_seq_assertions.sv ====
/*
  Port checker for the exposure sequencer.
  Assumes it is bound to the top module and that pclk is the only clock.
*/
`timescale 1ns/1ns
module rs_seq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic ext_trigger,
  input wire logic array_flush,
  input wire logic readout_active,
  input wire logic readout_discard,
  input wire logic row_strobe,
  input wire logic dummy_row_read,
  input wire logic trigger_ready,
  input wire logic expose_first,
  input wire logic expose_last,
  input wire logic expose_all,
  input wire logic expose_any
);
  import rs_seq_pkg::*;
  // ----------------------------------------------------------------------
  // Row gap counter
  // ----------------------------------------------------------------------
  // Saturates, so the first strobe after reset is never judged too early.
  logic [11:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 12'hfff;
    end else if (row_strobe) begin
      gap_q <= 12'h000;
    end else if (gap_q != 12'hfff) begin
      gap_q <= gap_q + 12'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_flush_a: assert property (trigger_ready |-> array_flush)
    else $error("ready seen without flush");
  read_flush_a: assert property (readout_active |-> !array_flush)
    else $error("flush held during readout");
  discard_read_a: assert property (readout_discard |-> readout_active)
    else $error("discard outside readout");
  all_any_a: assert property (expose_all |-> expose_any)
    else $error("all rows without any row");
  edge_rows_a: assert property (expose_first || expose_last |-> expose_any)
    else $error("row indicator without any row");
  idle_scan_a: assert property (dummy_row_read |-> trigger_ready && !readout_active)
    else $error("dummy row outside idle scan");
  row_gap_a: assert property (row_strobe |-> gap_q >= 12'(ROW_CLKS_SMALL - 1))
    else $error("row strobes too close");
  trig_take_a: assert property (ext_trigger && $past(ext_trigger) && trigger_ready
    && !$past(ext_trigger, 2) |-> ##[1:4] (readout_discard && !array_flush))
    else $error("trigger not answered");
  bad_addr_a: assert property (psel && penable && paddr > ROWCNT_ADDR |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind rs_exposure_sequencer rs_seq_checker chk_u (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .ext_trigger, .array_flush, .readout_active, .readout_discard, .row_strobe,
  .dummy_row_read, .trigger_ready, .expose_first, .expose_last, .expose_all, .expose_any);

// ==== testbench/trig_source.sv ====
/*
  Trigger source model: turns a one-cycle request into a trigger pulse.
  Assumes requests are spaced wider than the pulse.
*/
`timescale 1ns/1ns
module trig_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  output logic ext_trigger
);
  import rs_seq_pkg::*;
  logic [3:0] left_q;
  // The pulse is held for the shortest width the device must detect, no longer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 4'h0;
    end else if (fire && left_q == 4'h0) begin
      left_q <= 4'(TRIG_MIN_CLKS);
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  assign ext_trigger = (left_q != 4'h0);
endmodule

// ==== testbench/test_rs_exposure_sequencer.sv ====
/*
  Self-checking bench: APB tasks and one run per trigger mode.
  Assumes the design package, the trigger source model and the bound checker.
*/
`timescale 1ns/1ns
module test_rs_exposure_sequencer;
  import rs_seq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fire = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ext_trigger, array_flush, readout_active, readout_discard, er;
  logic row_strobe, dummy_row_read, trigger_ready, expose_first, expose_last;
  logic expose_all, expose_any;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, t1;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  rs_exposure_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_trigger, .array_flush, .readout_active,
    .readout_discard, .row_strobe, .dummy_row_read, .trigger_ready, .expose_first,
    .expose_last, .expose_all, .expose_any);
  trig_source src_u (.pclk, .presetn, .fire, .ext_trigger);
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic pick(input int k);
    case (k)
      0: pick = readout_discard;
      1: pick = readout_active;
      2: pick = array_flush;
      3: pick = trigger_ready;
      default: pick = dummy_row_read;
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // One APB transfer; an idle edge follows so back-to-back calls never collide.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    chk("pready", 32'h0000_0001, 32'(pready));
    if (pready !== 1'b1) end_sim();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Bounded wait for an output level; running out ends the run.
  task automatic wait_lvl(input int k, input logic v, input int lim);
    int i;
    i = 0;
    while (pick(k) !== v && i < lim) begin
      @(posedge pclk);
      i++;
    end
    chk("level", 32'(v), 32'(pick(k)));
    if (pick(k) !== v) end_sim();
  endtask
  task automatic start(input logic [31:0] ex, input logic [31:0] cy, input logic [31:0] c);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b1, ROWS_ADDR, 32'h0000_0004);
    xfer(1'b1, EXPO_ADDR, ex);
    xfer(1'b1, CYCLE_ADDR, cy);
    xfer(1'b1, CTRL_ADDR, c);
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  // Main sequence: reset values, internal, overlap, then external mode.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, EXPO_ADDR, ZERO32);
    chk("expo", EXPO_RST, rd);
    xfer(1'b0, CYCLE_ADDR, ZERO32);
    chk("cycle", CYCLE_RST, rd);
    xfer(1'b0, STATUS_ADDR, ZERO32);
    chk("status", 32'h0000_0010, rd & 32'h0000_00ff);
    xfer(1'b0, 12'h01c, ZERO32);
    chk("slverr", 32'h0000_0001, 32'(er));
    $display("test reset done");
    start(32'h0000_0001, 32'h0000_0008, 32'h0000_0001);
    wait_lvl(0, 1'b1, 4000);
    t0 = cyc;
    wait_lvl(0, 1'b0, 8000);
    chk("discard clks", 2 * ROW_CLKS_LARGE, cyc - t0);
    chk("any row", 32'h0000_0001, 32'(expose_any));
    chk("first row", 32'h0000_0000, 32'(expose_first));
    chk("last row", 32'h0000_0001, 32'(expose_last));
    wait_lvl(1, 1'b1, 4000);
    t1 = cyc;
    wait_lvl(1, 1'b0, 8000);
    chk("signal clks", 2 * ROW_CLKS_LARGE, cyc - t1);
    wait_lvl(2, 1'b1, 20);
    wait_lvl(0, 1'b1, 12000);
    chk("cycle clks", 8 * ROW_CLKS_LARGE, cyc - t0);
    $display("test internal done");
    start(32'h0000_0004, CYCLE_RST, 32'h0000_0005);
    wait_lvl(0, 1'b1, 4000);
    wait_lvl(0, 1'b0, 8000);
    wait_lvl(1, 1'b1, 12000);
    t0 = cyc;
    wait_lvl(1, 1'b0, 8000);
    repeat (4) @(posedge pclk);
    chk("all rows", 32'h0000_0001, 32'(expose_all));
    wait_lvl(1, 1'b1, 12000);
    // Row 1 re-exposes once it is read, one row into the readout, then for 4 rows.
    chk("overlap cycle", 5 * ROW_CLKS_LARGE, cyc - t0);
    chk("re-expose", 32'h0000_0001, 32'(expose_any));
    $display("test overlap done");
    start(32'h0000_0003, CYCLE_RST, 32'h0000_000b);
    wait_lvl(3, 1'b1, 4000);
    chk("idle flush", 32'h0000_0001, 32'(array_flush));
    wait_lvl(4, 1'b1, 6000);
    pulse();
    wait_lvl(0, 1'b1, 20);
    t0 = cyc;
    pulse();
    wait_lvl(0, 1'b0, 8000);
    chk("small discard", 2 * ROW_CLKS_SMALL, cyc - t0);
    wait_lvl(1, 1'b1, 12000);
    wait_lvl(1, 1'b0, 8000);
    wait_lvl(3, 1'b1, 40);
    repeat (20) @(posedge pclk);
    chk("no stale trig", 32'h0000_0000, 32'(readout_active));
    xfer(1'b1, SWTRIG_ADDR, 32'h0000_0001);
    wait_lvl(0, 1'b1, 20);
    $display("test external done");
    end_sim();
  end
endmodule
